/* hw/acrm_pkg.sv */
package acrm_pkg;
  // ==========================================================
  // Widths and address codes
  localparam int          ACRM_DW          = 32;
  localparam int          ACRM_AW          = 3;
  localparam int          ACRM_BANKS       = 4;
  localparam logic [2:0]  ACRM_ADDR_OFFSET = 3'h1;
  localparam logic [2:0]  ACRM_ADDR_GAIN   = 3'h2;
  localparam logic [2:0]  ACRM_ADDR_SETUP  = 3'h3;
  localparam logic [2:0]  ACRM_ADDR_CHAN   = 3'h5;
  // ==========================================================
  // Reset values
  localparam logic [31:0] ACRM_OFFSET_RST  = 32'h00000000;
  localparam logic [31:0] ACRM_GAIN_RST    = 32'h01000000;
  localparam logic [31:0] ACRM_SETUP_RST   = 32'h00000000;
  localparam logic [31:0] ACRM_CHAN_RST    = 32'h00000000;
  // ==========================================================
  // Field positions
  localparam int          ACRM_RFLAG_BIT   = 28;
  localparam int          ACRM_SRC_BIT     = 20;
  localparam int          ACRM_OLS_BIT     = 22;
  localparam int          ACRM_A1_BIT      = 24;
  localparam int          ACRM_A0_BIT      = 23;
  localparam int          ACRM_OL_LSB      = 4;
  localparam int          ACRM_PAIR_LSB    = 0;
  localparam int          ACRM_BANK_LSB    = 14;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [2:0]  addr;
    logic [1:0]  bank;
    logic [31:0] wdata;
  } acrm_cmd_type;

  typedef struct packed {
    logic [31:0] offset;
    logic [31:0] gain;
    logic [1:0]  sel;
  } acrm_cal_type;
endpackage

/* hw/acrm_regs.sv */
`timescale 1ns/1ps
// Function
// R1 - Thirteen 32-bit registers configure and control the converter.
// R2 - Registers are reached only by serial-port read and write commands.
// R3 - Every register takes its default on reset.
// R4 - Four offset copies, chosen by the 2-bit bank field of the command.
// R5 - Four gain copies, chosen by the same bank field.
// R6 - Applied pair comes from pair field or latch bits, per source choice bit.
// R7 - Address code 3'b001 selects the offset type.
// R8 - Offset is signed 32-bit, read-write, reset to zero.
// R9 - Address code 3'b010 selects the gain type.
// R10 - Gain is unsigned 32-bit, read-write.
// R11 - Gain resets to 0x01000000.
// R12 - Address code 3'b011 is the setup control word, reset to zero.
// R13 - Reset flag reads 1 after reset and clears once the word is read.
// R14 - Unused codes read zero and ignore writes.
module acrm_regs
  import acrm_pkg::*;
#(
  parameter int BANKS = acrm_pkg::ACRM_BANKS
)
(
  input  wire logic                  ref_clk,
  input  wire logic                  nrst,
  input  wire acrm_pkg::acrm_cmd_type cmd,
  output logic                       rd_valid,
  output logic [31:0]                rd_data,
  output acrm_pkg::acrm_cal_type     cal,
  output logic [31:0]                setup_word,
  output logic [31:0]                chan_words [4]
);
  import acrm_pkg::*;

  // ==========================================================
  // Storage
  logic [31:0] offset_reg [BANKS];
  logic [31:0] gain_reg   [BANKS];
  logic [31:0] setup_reg;
  logic [31:0] chan_reg   [4]; // [R1]
  logic        rflag_reg;

  logic        wr_en;
  logic        rd_en;
  assign wr_en = cmd.valid && cmd.write; // [R2]
  assign rd_en = cmd.valid && !cmd.write; // [R2]

  function automatic logic hit(input logic [2:0] a, input logic [2:0] code);
    hit = (a == code);
  endfunction

  function automatic logic mapped(input logic [2:0] a);
    mapped = hit(a, ACRM_ADDR_OFFSET) || hit(a, ACRM_ADDR_GAIN) ||
             hit(a, ACRM_ADDR_SETUP) || hit(a, ACRM_ADDR_CHAN);
  endfunction

  // ==========================================================
  // Calibration banks
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < BANKS; i++)
      begin
        offset_reg[i] <= ACRM_OFFSET_RST; // [R3] [R8]
        gain_reg[i]   <= ACRM_GAIN_RST; // [R11]
      end
    end
    else if (wr_en && hit(cmd.addr, ACRM_ADDR_OFFSET)) // [R7]
      offset_reg[cmd.bank] <= cmd.wdata; // [R4] [R8]
    else if (wr_en && hit(cmd.addr, ACRM_ADDR_GAIN)) // [R9]
      gain_reg[cmd.bank] <= cmd.wdata; // [R5] [R10]
  end

  // ==========================================================
  // Setup word and channel words
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      setup_reg <= ACRM_SETUP_RST; // [R12]
    else if (wr_en && hit(cmd.addr, ACRM_ADDR_SETUP))
      setup_reg <= cmd.wdata; // [R12]
  end

  // Channel word copy picked by the bank field too
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < 4; i++)
        chan_reg[i] <= ACRM_CHAN_RST; // [R3]
    end
    else if (wr_en && hit(cmd.addr, ACRM_ADDR_CHAN))
      chan_reg[cmd.bank] <= cmd.wdata;
  end

  // Flag is set by reset only, so no set/clear race exists
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      rflag_reg <= 1'b1; // [R13]
    else if (rd_en && hit(cmd.addr, ACRM_ADDR_SETUP))
      rflag_reg <= 1'b0; // [R13]
  end

  // ==========================================================
  // Read path, one cycle after the command
  logic [31:0] rd_next;
  always_comb
  begin
    rd_next = 32'h00000000; // [R14]
    if (hit(cmd.addr, ACRM_ADDR_OFFSET))
      rd_next = offset_reg[cmd.bank];
    else if (hit(cmd.addr, ACRM_ADDR_GAIN))
      rd_next = gain_reg[cmd.bank];
    else if (hit(cmd.addr, ACRM_ADDR_SETUP))
    begin
      rd_next = setup_reg;
      rd_next[ACRM_RFLAG_BIT] = rflag_reg; // [R13]
    end
    else if (hit(cmd.addr, ACRM_ADDR_CHAN))
      rd_next = chan_reg[cmd.bank];
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      rd_valid <= 1'b0;
      rd_data  <= 32'h00000000;
    end
    else
    begin
      rd_valid <= rd_en; // [R2]
      if (rd_en)
        rd_data <= rd_next;
    end
  end

  // ==========================================================
  // Applied calibration pair
  logic [1:0] sel_next;
  logic [31:0] chan0;
  assign chan0 = chan_reg[0];
  always_comb
  begin
    if (setup_reg[ACRM_SRC_BIT])
      sel_next = chan0[ACRM_PAIR_LSB +: 2]; // [R6]
    else
      sel_next = chan0[ACRM_OL_LSB +: 2]; // [R6]
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      cal <= '{offset: ACRM_OFFSET_RST, gain: ACRM_GAIN_RST, sel: 2'h0};
    else
      cal <= '{offset: offset_reg[sel_next], gain: gain_reg[sel_next], sel: sel_next}; // [R6]
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      setup_word <= ACRM_SETUP_RST;
    else
    begin
      setup_word <= setup_reg;
      setup_word[ACRM_RFLAG_BIT] <= rflag_reg;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      for (int i = 0; i < 4; i++)
        chan_words[i] <= ACRM_CHAN_RST;
    else
      for (int i = 0; i < 4; i++)
        chan_words[i] <= chan_reg[i];
  end

  // ==========================================================
  // Checks
  sequence reset_s;
    !nrst;
  endsequence

  sequence setup_read_s;
    rd_en && hit(cmd.addr, ACRM_ADDR_SETUP);
  endsequence

  sequence offset_write_s;
    wr_en && hit(cmd.addr, ACRM_ADDR_OFFSET);
  endsequence

  sequence gain_write_s;
    wr_en && hit(cmd.addr, ACRM_ADDR_GAIN);
  endsequence

  sequence setup_write_s;
    wr_en && hit(cmd.addr, ACRM_ADDR_SETUP);
  endsequence

  sequence chan_write_s;
    wr_en && hit(cmd.addr, ACRM_ADDR_CHAN);
  endsequence

  sequence unmapped_read_s;
    rd_en && !mapped(cmd.addr);
  endsequence

  sequence unmapped_write_s;
    wr_en && !mapped(cmd.addr);
  endsequence

  // Quiet cycle first, so the source registers cannot move under the pair
  sequence pair_src_s;
    (setup_reg[ACRM_SRC_BIT] && !wr_en) ##1 1'b1;
  endsequence

  sequence latch_src_s;
    (!setup_reg[ACRM_SRC_BIT] && !wr_en) ##1 1'b1;
  endsequence

  flag_clear_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R13]
    setup_read_s |=> !rflag_reg)
    else $error("reset flag not cleared");
  flag_reset_a: assert property (@(posedge ref_clk) // [R13]
    reset_s |=> rflag_reg)
    else $error("reset flag not set");
  flag_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R13]
    !(rd_en && hit(cmd.addr, ACRM_ADDR_SETUP)) |=> $stable(rflag_reg))
    else $error("reset flag moved without a read");
  gain_reset_a: assert property (@(posedge ref_clk) // [R11]
    reset_s |=> gain_reg[0] == ACRM_GAIN_RST && gain_reg[1] == ACRM_GAIN_RST &&
    gain_reg[2] == ACRM_GAIN_RST && gain_reg[3] == ACRM_GAIN_RST)
    else $error("gain reset wrong");
  offset_reset_a: assert property (@(posedge ref_clk) // [R8]
    reset_s |=> offset_reg[0] == ACRM_OFFSET_RST && offset_reg[1] == ACRM_OFFSET_RST &&
    offset_reg[2] == ACRM_OFFSET_RST && offset_reg[3] == ACRM_OFFSET_RST)
    else $error("offset reset wrong");
  setup_reset_a: assert property (@(posedge ref_clk) // [R12]
    reset_s |=> setup_reg == ACRM_SETUP_RST)
    else $error("setup reset wrong");
  chan_reset_a: assert property (@(posedge ref_clk) // [R3]
    reset_s |=> chan_reg[0] == ACRM_CHAN_RST && chan_reg[1] == ACRM_CHAN_RST &&
    chan_reg[2] == ACRM_CHAN_RST && chan_reg[3] == ACRM_CHAN_RST)
    else $error("channel reset wrong");
  out_reset_a: assert property (@(posedge ref_clk) // [R3]
    reset_s |=> !rd_valid && rd_data == 32'h00000000 && setup_word == ACRM_SETUP_RST &&
    cal.offset == ACRM_OFFSET_RST && cal.gain == ACRM_GAIN_RST && cal.sel == 2'h0)
    else $error("output reset wrong");
  offset_write_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R7]
    offset_write_s |=> offset_reg[$past(cmd.bank)] == $past(cmd.wdata))
    else $error("offset write lost");
  gain_write_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R9]
    gain_write_s |=> gain_reg[$past(cmd.bank)] == $past(cmd.wdata))
    else $error("gain write lost");
  setup_write_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R12]
    setup_write_s |=> setup_reg == $past(cmd.wdata))
    else $error("setup write lost");
  chan_write_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R1]
    chan_write_s |=> chan_reg[$past(cmd.bank)] == $past(cmd.wdata))
    else $error("channel write lost");
  offset_read_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R4]
    rd_en && hit(cmd.addr, ACRM_ADDR_OFFSET) |=> rd_valid &&
    rd_data == offset_reg[$past(cmd.bank)])
    else $error("offset read wrong");
  gain_read_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R5]
    rd_en && hit(cmd.addr, ACRM_ADDR_GAIN) |=> rd_valid &&
    rd_data == gain_reg[$past(cmd.bank)])
    else $error("gain read wrong");
  chan_read_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R1]
    rd_en && hit(cmd.addr, ACRM_ADDR_CHAN) |=> rd_valid &&
    rd_data == chan_reg[$past(cmd.bank)])
    else $error("channel read wrong");
  setup_read_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R13]
    setup_read_s |=> rd_valid && rd_data[ACRM_RFLAG_BIT] == $past(rflag_reg))
    else $error("setup read flag wrong");
  unused_read_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R14]
    unmapped_read_s |=> rd_valid && rd_data == 32'h00000000)
    else $error("unused read nonzero");
  unused_write_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R14]
    unmapped_write_s |=> $stable(setup_reg) && $stable(gain_reg[0]) &&
    $stable(offset_reg[0]) && $stable(chan_reg[0]))
    else $error("unused write changed state");
  read_latency_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R2]
    rd_en |=> rd_valid)
    else $error("read answer late");
  read_single_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R2]
    !rd_en |=> !rd_valid)
    else $error("read answer without a read");
  data_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R2]
    !rd_en |=> $stable(rd_data))
    else $error("read data moved without a read");
  pair_sel_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R6]
    setup_reg[ACRM_SRC_BIT] ##1 (setup_reg[ACRM_SRC_BIT] && $stable(chan_reg[0]))
    |-> cal.sel == chan_reg[0][ACRM_PAIR_LSB +: 2])
    else $error("pair select wrong");
  pair_cal_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R6]
    pair_src_s |-> cal.sel == chan_reg[0][ACRM_PAIR_LSB +: 2] &&
    cal.offset == offset_reg[cal.sel] && cal.gain == gain_reg[cal.sel])
    else $error("pair field calibration wrong");
  latch_cal_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R6]
    latch_src_s |-> cal.sel == chan_reg[0][ACRM_OL_LSB +: 2] &&
    cal.offset == offset_reg[cal.sel] && cal.gain == gain_reg[cal.sel])
    else $error("latch bits calibration wrong");
  setup_copy_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R12]
    !wr_en |=> setup_word[ACRM_RFLAG_BIT] == $past(rflag_reg) &&
    setup_word[ACRM_SRC_BIT] == setup_reg[ACRM_SRC_BIT])
    else $error("setup copy wrong");
  chan_copy_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R3]
    !wr_en |=> chan_words[0] == chan_reg[0] &&
    chan_words[3] == chan_reg[3])
    else $error("channel copy wrong");
endmodule

/* bench/acrm_host.sv */
`timescale 1ns/1ps
// ==========================================================
// Host model: one register command per call
module acrm_host
(
  input  wire logic              ref_clk,
  output acrm_pkg::acrm_cmd_type cmd,
  input  wire logic              rd_valid,
  input  wire logic [31:0]       rd_data
);
  import acrm_pkg::*;
  initial cmd = '0;
  // Entered 1 ns after an edge; released address, bank and data lines show inverted values, valid and write go low
  task automatic xfer(input logic w, input logic [2:0] a, input logic [1:0] b,
                      input logic [31:0] d, output logic [31:0] q, output logic ok);
    cmd = '{1'b1, w, a, b, d};
    @(posedge ref_clk);
    #1 cmd = '{1'b0, 1'b0, ~a, ~b, ~d};
    ok = 1'b1;
    q = 32'h00000000;
    // Answer stands for the cycle after the taking edge; take it at its end
    @(posedge ref_clk);
    if (!w)
    begin
      ok = (rd_valid === 1'b1);
      q = rd_data;
    end
    #1;
  endtask
endmodule

/* bench/acrm_regs_tb.sv */
`timescale 1ns/1ps
// ==========================================================
// Register bank bench
module acrm_regs_tb;
  import acrm_pkg::*;
  logic         ref_clk = 1'b0;
  logic         nrst    = 1'b0;
  acrm_cmd_type cmd;
  logic         rd_valid;
  logic [31:0]  rd_data;
  acrm_cal_type cal;
  logic [31:0]  setup_word;
  logic [31:0]  chan_words [4];
  logic [2:0]   unused [4] = '{3'h0, 3'h4, 3'h6, 3'h7};
  int           error_cnt = 0;
  int           checks    = 0;
  int           i;
  always #12.5 ref_clk = ~ref_clk;
  acrm_regs DUT (.ref_clk(ref_clk), .nrst(nrst), .cmd(cmd), .rd_valid(rd_valid),
    .rd_data(rd_data), .cal(cal), .setup_word(setup_word), .chan_words(chan_words));
  acrm_host host (.ref_clk(ref_clk), .cmd(cmd), .rd_valid(rd_valid), .rd_data(rd_data));
  // ==========================================================
  // Helpers
  task automatic complete_run();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [1:0] b, input logic [31:0] d);
    logic [31:0] q;
    logic        ok;
    host.xfer(1'b1, a, b, d, q, ok);
  endtask
  // Answer is due exactly one cycle later; a missing one ends the run
  task automatic rd(input logic [2:0] a, input logic [1:0] b, input logic [31:0] exp);
    logic [31:0] q;
    logic        ok;
    host.xfer(1'b0, a, b, 32'h00000000, q, ok);
    if (ok !== 1'b1)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, ok, 1'b1);
      complete_run();
    end
    else
      chk(q, exp);
  endtask
  task automatic rst_seq();
    nrst = 1'b0;
    repeat (12) @(posedge ref_clk);
    #1 nrst = 1'b1;
    @(posedge ref_clk);
    #1;
  endtask
  // Calibration outputs lag register state by one cycle
  task automatic settle();
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  // ==========================================================
  // Sequence
  initial
  begin
    rst_seq();
    rd(3'h3, 2'h0, 32'h10000000);
    rd(3'h3, 2'h0, 32'h00000000);
    for (i = 0; i < 4; i++)
    begin
      rd(3'h1, i[1:0], 32'h00000000);
      rd(3'h2, i[1:0], 32'h01000000);
      rd(3'h5, i[1:0], 32'h00000000);
      wr(3'h1, i[1:0], 32'hF0000000 | i);
      wr(3'h2, i[1:0], 32'h0A000000 + i);
      wr(3'h5, i[1:0], 32'h00C00000 + i);
    end
    for (i = 0; i < 4; i++)
    begin
      rd(3'h1, i[1:0], 32'hF0000000 | i);
      rd(3'h2, i[1:0], 32'h0A000000 + i);
      rd(3'h5, i[1:0], 32'h00C00000 + i);
    end
    for (i = 0; i < 4; i++)
    begin
      wr(unused[i], 2'h0, 32'hFFFFFFFF);
      rd(unused[i], 2'h0, 32'h00000000);
    end
    rd(3'h1, 2'h0, 32'hF0000000);
    wr(3'h5, 2'h0, 32'h00000032);
    settle();
    chk({30'h0, cal.sel}, 32'h00000003);
    chk(cal.offset, 32'hF0000003);
    chk(cal.gain, 32'h0A000003);
    chk(chan_words[0], 32'h00000032);
    chk(chan_words[3], 32'h00C00003);
    rd(3'h5, 2'h0, 32'h00000032);
    wr(3'h3, 2'h0, 32'h10100000);
    rd(3'h3, 2'h0, 32'h00100000);
    settle();
    chk(setup_word, 32'h00100000);
    chk({30'h0, cal.sel}, 32'h00000002);
    chk(cal.gain, 32'h0A000002);
    rst_seq();
    chk(chan_words[0], 32'h00000000);
    chk(cal.gain, 32'h01000000);
    rd(3'h2, 2'h1, 32'h01000000);
    rd(3'h1, 2'h2, 32'h00000000);
    rd(3'h3, 2'h0, 32'h10000000);
    complete_run();
  end
endmodule
